/* File: decode_pkg.sv */
// constants, opcode layout and carrier types for the operand field decoder
// Function
// - general register operand is an 8-bit address, 00h to FFh
// - peripheral register operand is a 5-bit address, 00h to 1Fh
// - table post_bump 1 increments table_pointer after execution, 0 leaves it
// - table half_sel 0 uses table_latch low byte, 1 the high byte
// - result_target 0 writes accumulator, 1 writes the addressed register
// - dual_write 0 writes register and accumulator, 1 only the register
// - pos_in_reg selects the single bit of the addressed register
// - ripple_out, nibble_carry, null_result, signed_wrap flags kept and updated
// - global_irq_mask lives at bit 4 of cpu_state_reg
// - table_latch is 16 bits of high and low bytes; table_pointer 16 bits
// - unused encoding bits are zero; decoder expects that
// - don't-care bits are ignored; either value behaves the same
// - unassigned opcodes are reserved with no defined effect
// - input is a 16-bit word of opcode then operand fields
package decode_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC   = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_CPUST = 8'h0c;
	localparam logic [7:0] OFS_TPTR  = 8'h10;
	localparam logic [7:0] OFS_TLAT  = 8'h14;
	localparam logic [7:0] OFS_FSEL  = 8'h18;
	localparam logic [7:0] OFS_FDATA = 8'h1c;
	localparam logic [7:0] OFS_DSTAT = 8'h20;
	// field positions inside the instruction word and registers
	localparam int POS_DSEL = 8;
	localparam int POS_TSEL = 9;
	localparam int POS_BSET = 11;
	localparam int POS_IRQM = 4;
	localparam int POS_RSV  = 0;
	localparam int POS_UNU  = 1;
	// reset and fill values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [1:0]  RST_DSTAT = 2'h0;
	// opcode patterns, matched on the named upper bits
	localparam logic [7:0] OPC_NOP   = 8'h00;
	localparam logic [7:0] OPC_MOVWF = 8'h01;
	localparam logic [2:0] OPC_MOVPF = 3'h2;
	localparam logic [2:0] OPC_MOVFP = 3'h3;
	localparam logic [2:0] OPC_BIT   = 3'h4;
	localparam logic [5:0] OPC_TRD   = 6'h2a;
	localparam logic [5:0] OPC_TWR   = 6'h2b;
	localparam logic [6:0] OPC_SUB   = 7'h02;
	localparam logic [6:0] OPC_DEC   = 7'h03;
	localparam logic [6:0] OPC_IOR   = 7'h04;
	localparam logic [6:0] OPC_AND   = 7'h05;
	localparam logic [6:0] OPC_ADD   = 7'h07;
	localparam logic [6:0] OPC_COM   = 7'h09;
	localparam logic [6:0] OPC_INC   = 7'h0a;
	localparam logic [6:0] OPC_SWAP  = 7'h0e;
	localparam logic [6:0] OPC_CLR   = 7'h14;
	localparam logic [6:0] OPC_SET   = 7'h15;

	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_AND, OP_IOR, OP_SUB, OP_DEC, OP_INC, OP_COM,
		OP_SWAP, OP_MOVWF, OP_CLR, OP_SET, OP_MOVFP, OP_MOVPF, OP_BCF,
		OP_BSF, OP_TRD, OP_TWR, OP_RSV
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FETCH = 3'b010,
		S_EXEC  = 3'b100
	} state_t;

	typedef struct packed {
		logic signed_wrap;
		logic null_result;
		logic nibble_carry;
		logic ripple_out;
	} flags_t;

	typedef struct packed {
		op_t        op;
		logic [7:0] f;
		logic [4:0] p;
		logic [2:0] bpos;
		logic       dsel;
		logic       tsel;
		logic       bump;
		logic       unused_bad;
	} dec_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic       we;
	} mem_wr_t;
endpackage : decode_pkg

/* File: file_mem.sv */
// register file storage with registered read data
`timescale 1ns/1ps
module file_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8,
	parameter int DW    = 8
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	if (DEPTH < 32 || DEPTH > (1 << AW)) begin : g_chk
		$error("file_mem depth out of range");
	end

	// write port; addresses above depth fold back
	always_ff @(posedge pclk) begin
		if (we)
			mem[int'(waddr) % DEPTH] <= wdata;
	end

	// registered read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata <= '0;
		else
			rdata <= mem[int'(raddr) % DEPTH];
	end
endmodule : file_mem

/* File: alu_unit.sv */
// byte alu: result, status flags and which flags the operation updates
`timescale 1ns/1ps
module alu_unit
	import decode_pkg::*;
(
	// operands
	input  wire decode_pkg::op_t    op,
	input  wire logic [7:0]         a,
	input  wire logic [7:0]         w,
	// results
	output logic      [7:0]         res,
	output decode_pkg::flags_t      flg,
	output decode_pkg::flags_t      upd
);
	logic [8:0] sum;
	logic [4:0] nib;

	// arithmetic and logic with flag generation
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		res = a;
		flg = '0;
		upd = '0;
		unique case (op)
			OP_ADD: begin
				sum = {1'b0, a} + {1'b0, w};
				nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
				res = sum[7:0];
				flg.ripple_out   = sum[8];
				flg.nibble_carry = nib[4];
				flg.signed_wrap  = (a[7] == w[7]) && (res[7] != a[7]);
				upd = '1;
			end
			OP_SUB: begin
				res = a - w;
				flg.ripple_out   = a >= w; // carry means no borrow
				flg.nibble_carry = a[3:0] >= w[3:0];
				flg.signed_wrap  = (a[7] != w[7]) && (res[7] != a[7]);
				upd = '1;
			end
			OP_INC: begin
				res = a + 8'h01;
				flg.ripple_out   = a == 8'hff;
				flg.nibble_carry = a[3:0] == 4'hf;
				flg.signed_wrap  = a == 8'h7f;
				upd = '1;
			end
			OP_DEC: begin
				res = a - 8'h01;
				flg.ripple_out   = a != 8'h00;
				flg.nibble_carry = a[3:0] != 4'h0;
				flg.signed_wrap  = a == 8'h80;
				upd = '1;
			end
			OP_AND:   begin res = a & w; upd.null_result = 1'b1; end
			OP_IOR:   begin res = a | w; upd.null_result = 1'b1; end
			OP_COM:   begin res = ~a; upd.null_result = 1'b1; end
			OP_MOVPF: begin res = a; upd.null_result = 1'b1; end
			OP_SWAP:  res = {a[3:0], a[7:4]};
			default:  res = a;
		endcase
		flg.null_result = res == 8'h00;
	end
endmodule : alu_unit

/* File: operand_field_decoder.sv */
// apb-reached operand field decoder and executor for the 8-bit core
`timescale 1ns/1ps
module operand_field_decoder #(
	parameter int FILE_WORDS = 256
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core status
	output logic             global_irq_mask
);
	import decode_pkg::*;
	if (FILE_WORDS < 32 || FILE_WORDS > 256) begin : g_chk
		$error("FILE_WORDS must be 32 to 256");
	end
	state_t     state;
	logic [15:0] instr;
	dec_t       dec;
	dec_t       dec_in;
	logic [7:0] acc;
	flags_t     flags;
	logic [7:0] cpu_state;
	logic [15:0] tbl_ptr;
	logic [15:0] tbl_latch;
	logic [7:0] file_sel;
	logic [1:0] dstat;
	logic       fdata_rd;
	logic [7:0] mem_raddr;
	logic [7:0] mem_rdata;
	mem_wr_t    mem_wr;
	logic [7:0] alu_res;
	flags_t     alu_flg;
	flags_t     alu_upd;
	logic       bus_req;
	logic       bus_wr;
	logic       slow;
	logic       mapped;
	logic [31:0] rd_mux;
	logic       exec_ins;
	logic       is_dop;
	logic [7:0] bit_mask;
	// instruction word split into operand fields
	function automatic dec_t decode(input logic [15:0] w);
		dec_t d;
		d.f          = w[7:0];
		d.p          = w[12:8];
		d.bpos       = w[10:8];
		d.dsel       = w[POS_DSEL];
		d.tsel       = w[POS_TSEL];
		d.bump       = w[POS_DSEL];
		d.unused_bad = 1'b0;
		d.op         = OP_RSV;
		if (w[15:8] == OPC_NOP) begin
			d.op         = OP_NOP;
			d.unused_bad = |w[7:0];
		end else if (w[15:8] == OPC_MOVWF)
			d.op = OP_MOVWF;
		else if (w[15:13] == OPC_MOVPF)
			d.op = OP_MOVPF;
		else if (w[15:13] == OPC_MOVFP)
			d.op = OP_MOVFP;
		else if (w[15:13] == OPC_BIT)      // bit 12 not looked at
			d.op = w[POS_BSET] ? OP_BSF : OP_BCF;
		else if (w[15:10] == OPC_TRD)
			d.op = OP_TRD;
		else if (w[15:10] == OPC_TWR)
			d.op = OP_TWR;
		else begin
			case (w[15:9])
				OPC_SUB:  d.op = OP_SUB;
				OPC_DEC:  d.op = OP_DEC;
				OPC_IOR:  d.op = OP_IOR;
				OPC_AND:  d.op = OP_AND;
				OPC_ADD:  d.op = OP_ADD;
				OPC_COM:  d.op = OP_COM;
				OPC_INC:  d.op = OP_INC;
				OPC_SWAP: d.op = OP_SWAP;
				OPC_CLR:  d.op = OP_CLR;
				OPC_SET:  d.op = OP_SET;
				default:  d.op = OP_RSV;
			endcase
		end
		return d;
	endfunction : decode

	// bus request qualifiers; only taken while idle
	assign bus_req  = psel && penable && !pready && (state == S_IDLE);
	assign bus_wr   = bus_req && pwrite;
	assign dec_in   = decode(pwdata[15:0]);
	assign exec_ins = (state == S_EXEC) && !fdata_rd;
	assign is_dop   = dec.op inside {OP_ADD, OP_AND, OP_IOR, OP_SUB,
	                                 OP_DEC, OP_INC, OP_COM, OP_SWAP};
	assign bit_mask = 8'h01 << dec.bpos;
	assign slow     = (pwrite && paddr == OFS_INSTR) || (!pwrite && paddr == OFS_FDATA);
	assign global_irq_mask = cpu_state[POS_IRQM];

	// read data select and address map
	always_comb begin
		rd_mux = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			OFS_INSTR: rd_mux = 32'(instr);
			OFS_ACC:   rd_mux = 32'(acc);
			OFS_FLAGS: rd_mux = 32'(flags);
			OFS_CPUST: rd_mux = 32'(cpu_state);
			OFS_TPTR:  rd_mux = 32'(tbl_ptr);
			OFS_TLAT:  rd_mux = 32'(tbl_latch);
			OFS_FSEL:  rd_mux = 32'(file_sel);
			OFS_FDATA: rd_mux = 32'h0000_0000;
			OFS_DSTAT: rd_mux = {19'h00000, dec.op, 6'h00, dstat};
			default:   mapped = 1'b0;
		endcase
	end

	// bus handshake and execution sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= S_IDLE;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			fdata_rd <= 1'b0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (bus_req && slow) begin
						state    <= S_FETCH;
						fdata_rd <= !pwrite;
					end else if (bus_req) begin
						pready  <= 1'b1;
						pslverr <= !mapped;
						prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
					end
				end
				S_FETCH: state <= S_EXEC;
				S_EXEC: begin
					state  <= S_IDLE;
					pready <= 1'b1;
					prdata <= fdata_rd ? 32'(mem_rdata) : 32'h0000_0000;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// latched instruction and its decoded fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= RST_WORD;
			dec   <= '{op: OP_NOP, default: '0}; // same fields as a decoded all-zero word
		end else if (bus_wr && paddr == OFS_INSTR) begin
			instr <= pwdata[15:0];
			dec   <= dec_in;
		end
	end

	// operand read address: peripheral slot for move-from-peripheral
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mem_raddr <= RST_BYTE;
		else if (bus_req && slow)
			mem_raddr <= !pwrite ? file_sel :
			             (dec_in.op == OP_MOVPF) ? 8'(dec_in.p) : dec_in.f;
	end

	// register file write port: software window or executed result
	always_comb begin
		mem_wr.addr = file_sel;
		mem_wr.data = pwdata[7:0];
		mem_wr.we   = bus_wr && paddr == OFS_FDATA;
		if (exec_ins) begin
			mem_wr.addr = dec.f;
			mem_wr.data = alu_res;
			mem_wr.we   = 1'b0;
			unique case (dec.op)
				OP_ADD, OP_AND, OP_IOR, OP_SUB, OP_DEC, OP_INC, OP_COM, OP_SWAP:
					mem_wr.we = dec.dsel;
				OP_MOVWF: begin
					mem_wr.data = acc;
					mem_wr.we   = 1'b1;
				end
				OP_CLR, OP_SET: begin
					mem_wr.data = (dec.op == OP_SET) ? BYTE_ONES : RST_BYTE;
					mem_wr.we   = 1'b1;
				end
				OP_MOVFP: begin
					mem_wr.addr = 8'(dec.p);
					mem_wr.data = mem_rdata;
					mem_wr.we   = 1'b1;
				end
				OP_MOVPF: begin
					mem_wr.data = mem_rdata;
					mem_wr.we   = 1'b1;
				end
				OP_BCF, OP_BSF: begin
					mem_wr.data = (dec.op == OP_BSF) ? (mem_rdata | bit_mask)
					                                 : (mem_rdata & ~bit_mask);
					mem_wr.we   = 1'b1;
				end
				OP_TRD: begin
					mem_wr.data = dec.tsel ? tbl_latch[15:8] : tbl_latch[7:0];
					mem_wr.we   = 1'b1;
				end
				default: mem_wr.we = 1'b0;
			endcase
		end
	end

	// accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc <= RST_BYTE;
		else if (bus_wr && paddr == OFS_ACC)
			acc <= pwdata[7:0];
		else if (exec_ins && is_dop && !dec.dsel)
			acc <= alu_res;
		else if (exec_ins && dec.op == OP_CLR && !dec.dsel)
			acc <= RST_BYTE;
		else if (exec_ins && dec.op == OP_SET && !dec.dsel)
			acc <= BYTE_ONES;
	end

	// alu status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags <= '0;
		else if (bus_wr && paddr == OFS_FLAGS)
			flags <= flags_t'(pwdata[3:0]);
		else if (exec_ins)
			flags <= (flags & ~alu_upd) | (alu_flg & alu_upd);
	end

	// cpu state register holding the interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cpu_state <= RST_BYTE;
		else if (bus_wr && paddr == OFS_CPUST)
			cpu_state <= pwdata[7:0];
	end

	// table pointer with wrapping post increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tbl_ptr <= RST_WORD;
		else if (bus_wr && paddr == OFS_TPTR)
			tbl_ptr <= pwdata[15:0];
		else if (exec_ins && dec.op inside {OP_TRD, OP_TWR} && dec.bump)
			tbl_ptr <= tbl_ptr + 16'h0001;
	end

	// table latch, byte loaded by table write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tbl_latch <= RST_WORD;
		else if (bus_wr && paddr == OFS_TLAT)
			tbl_latch <= pwdata[15:0];
		else if (exec_ins && dec.op == OP_TWR && dec.tsel)
			tbl_latch[15:8] <= mem_rdata;
		else if (exec_ins && dec.op == OP_TWR)
			tbl_latch[7:0] <= mem_rdata;
	end

	// software file window address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			file_sel <= RST_BYTE;
		else if (bus_wr && paddr == OFS_FSEL)
			file_sel <= pwdata[7:0];
	end

	// sticky decode status, write one to clear, hardware set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dstat <= RST_DSTAT;
		else begin
			if (bus_wr && paddr == OFS_DSTAT)
				dstat <= dstat & ~pwdata[1:0];
			if (exec_ins && dec.op == OP_RSV)
				dstat[POS_RSV] <= 1'b1;
			if (exec_ins && dec.unused_bad)
				dstat[POS_UNU] <= 1'b1;
		end
	end

	// datapath instances
	alu_unit u_alu (
		.op  (dec.op),
		.a   (mem_rdata),
		.w   (acc),
		.res (alu_res),
		.flg (alu_flg),
		.upd (alu_upd)
	);

	file_mem #(
		.DEPTH (FILE_WORDS),
		.AW    (8),
		.DW    (8)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (mem_wr.we),
		.waddr   (mem_wr.addr),
		.wdata   (mem_wr.data),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);

	// checks next to the logic
	property p_instr_latency;
		@(posedge pclk) disable iff (!presetn)
		(bus_wr && paddr == OFS_INSTR) |=> (state == S_FETCH) ##1 (state == S_EXEC) ##1 pready;
	endproperty
	a_instr_latency: assert property (p_instr_latency) else $error("instr not done in 3");
	property p_acc_target;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && is_dop && !dec.dsel) |=> (acc == $past(alu_res));
	endproperty
	a_acc_target: assert property (p_acc_target) else $error("acc missed result");
	property p_reg_target;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && is_dop && dec.dsel) |-> (mem_wr.we && mem_wr.addr == dec.f) ##1 $stable(acc);
	endproperty
	a_reg_target: assert property (p_reg_target) else $error("register target wrong");
	property p_dual_write;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op == OP_CLR && !dec.dsel) |-> mem_wr.we ##1 (acc == RST_BYTE);
	endproperty
	a_dual_write: assert property (p_dual_write) else $error("dual write missed acc");
	property p_ptr_bump;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op == OP_TRD && dec.bump) |=> (tbl_ptr == $past(tbl_ptr) + 16'h0001);
	endproperty
	a_ptr_bump: assert property (p_ptr_bump) else $error("pointer not bumped");
	property p_ptr_hold;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op inside {OP_TRD, OP_TWR} && !dec.bump) |=> $stable(tbl_ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_half_sel;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op == OP_TRD) |-> (mem_wr.we && mem_wr.addr == instr[7:0] &&
			mem_wr.data == (instr[POS_TSEL] ? tbl_latch[15:8] : tbl_latch[7:0]));
	endproperty
	a_half_sel: assert property (p_half_sel) else $error("wrong latch byte");
	property p_bit_pos;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op == OP_BSF) |->
			(mem_wr.data[dec.bpos] && ((mem_wr.data ^ mem_rdata) & ~bit_mask) == 8'h00);
	endproperty
	a_bit_pos: assert property (p_bit_pos) else $error("bit op wrong bit");
	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		(exec_ins && dec.op == OP_RSV) |-> !mem_wr.we ##1 (dstat[POS_RSV] && $stable(acc));
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved had effect");
endmodule : operand_field_decoder

/* File: operand_field_decoder_tb.sv */
// self-checking apb testbench for the operand field decoder
`timescale 1ns/1ps
module operand_field_decoder_tb;
	import decode_pkg::*;
	// clock, reset and apb drive
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        global_irq_mask;
	// bench bookkeeping
	int          n_fail;
	int          comparisons;
	logic [31:0] rdat;
	logic        rerr;
	logic [7:0]  expv;
	logic [7:0]  acc_in [3] = '{8'h03, 8'hff, 8'h7f};
	logic [7:0]  sum_ex [3] = '{8'h08, 8'h00, 8'h80};
	logic [3:0]  flg_ex [3] = '{4'h0, 4'h7, 4'ha};
	// remaining byte operations: file 8'h80, accumulator 8'h01, flags preset 4'hb
	logic [7:0]  op_hi  [7] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h12, 8'h14, 8'h1c};
	logic [7:0]  op_res [7] = '{8'h7f, 8'h7f, 8'h81, 8'h00, 8'h7f, 8'h81, 8'h08};
	logic [3:0]  op_flg [7] = '{4'h9, 4'h9, 4'hb, 4'hf, 4'hb, 4'h0, 4'hb};

	operand_field_decoder #(.FILE_WORDS(256)) operand_field_decoder_inst (
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.global_irq_mask (global_irq_mask)
	);

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// verdict and end of run
	task automatic test_done;
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	// compare one value and count it
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask : chk

	// one apb transfer: setup, access, wait for pready under a bound
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1) break;
			n++;
			if (n > 100) begin
				$display("BAD pready expected 1 seen timeout");
				n_fail++;
				test_done();
			end
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// register and file helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		xfer(1'b0, a, 32'h0);
		chk(name, exp, rdat);
	endtask : rd

	task automatic run(input logic [15:0] w);
		wr(OFS_INSTR, {16'h0000, w});
	endtask : run

	task automatic fput(input logic [7:0] f, input logic [7:0] d);
		wr(OFS_FSEL, {24'h0, f});
		wr(OFS_FDATA, {24'h0, d});
	endtask : fput

	task automatic fchk(input logic [7:0] f, input logic [7:0] exp);
		wr(OFS_FSEL, {24'h0, f});
		rd(OFS_FDATA, {24'h0, exp}, "file");
	endtask : fchk

	// main sequence
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		n_fail  = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// reset state
		rd(OFS_FLAGS, 32'h0, "flags");
		rd(OFS_TPTR, 32'h0, "tptr");
		rd(OFS_TLAT, 32'h0, "tlat");
		chk("irq_mask", 32'h0, {31'h0, global_irq_mask});
		// interrupt mask bit follows bit 4 of the cpu state register
		wr(OFS_CPUST, 32'h10);
		rd(OFS_CPUST, 32'h10, "cpust");
		chk("irq_mask", 32'h1, {31'h0, global_irq_mask});
		wr(OFS_CPUST, 32'hef);
		rd(OFS_CPUST, 32'hef, "cpust");
		chk("irq_mask", 32'h0, {31'h0, global_irq_mask});
		// full 8-bit file reach at both ends
		wr(OFS_ACC, 32'h3c);
		run(16'h01ff);
		fchk(8'hff, 8'h3c);
		wr(OFS_ACC, 32'hc3);
		run(16'h0100);
		fchk(8'h00, 8'hc3);
		fchk(8'hff, 8'h3c);
		// add with destination to accumulator, flags from a table
		for (int i = 0; i < 3; i++) begin
			fput(8'h10, (i == 0) ? 8'h05 : 8'h01);
			wr(OFS_ACC, {24'h0, acc_in[i]});
			run(16'h0e10);
			rd(OFS_ACC, {24'h0, sum_ex[i]}, "acc");
			rd(OFS_FLAGS, {28'h0, flg_ex[i]}, "flags");
			fchk(8'h10, (i == 0) ? 8'h05 : 8'h01);
		end
		// destination back to the file register
		fput(8'h10, 8'h05);
		wr(OFS_ACC, 32'h03);
		run(16'h0f10);
		fchk(8'h10, 8'h08);
		rd(OFS_ACC, 32'h03, "acc");
		// subtract, decrement, or, and, complement, increment, swap into the accumulator
		fput(8'h50, 8'h80);
		for (int i = 0; i < 7; i++) begin
			wr(OFS_ACC, 32'h01);
			wr(OFS_FLAGS, 32'hb);
			run({op_hi[i], 8'h50});
			rd(OFS_ACC, {24'h0, op_res[i]}, "acc");
			rd(OFS_FLAGS, {28'h0, op_flg[i]}, "flags");
		end
		fchk(8'h50, 8'h80);
		// set and clear with the dual-write select
		wr(OFS_ACC, 32'h11);
		fput(8'h40, 8'h22);
		run(16'h2b40);
		fchk(8'h40, 8'hff);
		rd(OFS_ACC, 32'h11, "acc");
		run(16'h2840);
		fchk(8'h40, 8'h00);
		rd(OFS_ACC, 32'h00, "acc");
		run(16'h2a40);
		fchk(8'h40, 8'hff);
		rd(OFS_ACC, 32'hff, "acc");
		// peripheral window at its top address, both directions
		fput(8'ha0, 8'h3c);
		run(16'h7fa0);
		fchk(8'h1f, 8'h3c);
		fput(8'h1f, 8'h96);
		run(16'h5fa1);
		fchk(8'ha1, 8'h96);
		// every bit position set then cleared, don't-care bit toggled
		fput(8'h20, 8'h00);
		expv = 8'h00;
		for (int b = 0; b < 8; b++) begin
			run(16'h8820 | (16'(b) << 8) | ((b % 2) ? 16'h1000 : 16'h0000));
			expv[b] = 1'b1;
			fchk(8'h20, expv);
		end
		for (int b = 7; b >= 0; b--) begin
			run(16'h8020 | (16'(b) << 8) | ((b % 2) ? 16'h0000 : 16'h1000));
			expv[b] = 1'b0;
			fchk(8'h20, expv);
		end
		// table read with bump at the pointer's top, then without bump
		wr(OFS_TLAT, 32'ha55a);
		wr(OFS_TPTR, 32'hffff);
		wr(OFS_FLAGS, 32'h0);
		run(16'hab30);
		fchk(8'h30, 8'ha5);
		rd(OFS_TPTR, 32'h0000, "tptr");
		rd(OFS_FLAGS, 32'h0, "flags");
		run(16'ha831);
		fchk(8'h31, 8'h5a);
		rd(OFS_TPTR, 32'h0000, "tptr");
		// table write to each latch byte
		fput(8'h32, 8'h77);
		run(16'haf32);
		rd(OFS_TLAT, 32'h775a, "tlat");
		rd(OFS_TPTR, 32'h0001, "tptr");
		run(16'hac32);
		rd(OFS_TLAT, 32'h7777, "tlat");
		rd(OFS_TPTR, 32'h0001, "tptr");
		// nonzero unused bits, then a reserved opcode with no effect
		wr(OFS_ACC, 32'h55);
		run(16'h0001);
		rd(OFS_DSTAT, 32'h2, "dstat");
		run(16'hf000);
		rd(OFS_DSTAT, (32'(OP_RSV) << 8) | 32'h3, "dstat");
		rd(OFS_ACC, 32'h55, "acc");
		wr(OFS_DSTAT, 32'h3);
		rd(OFS_DSTAT, 32'(OP_RSV) << 8, "dstat");
		// unmapped address is refused, mapped one is not
		xfer(1'b1, 8'h24, 32'hffff_ffff);
		chk("pslverr", 32'h1, {31'h0, rerr});
		xfer(1'b0, 8'h24, 32'h0);
		chk("pslverr", 32'h1, {31'h0, rerr});
		chk("prdata", 32'h0, rdat);
		xfer(1'b0, OFS_ACC, 32'h0);
		chk("pslverr", 32'h0, {31'h0, rerr});
		test_done();
	end
endmodule : operand_field_decoder_tb
